// >>> adcpp_pkg.sv
package adcpp_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int CHAN_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLKS_PER_SAMPLE = 16;
  localparam logic [3:0] CONV_CNT_LAST = 4'(CLKS_PER_SAMPLE - 1);
  localparam logic [3:0] CONV_CNT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Channel address codes, high bit first
  // ----------------------------------------------------------------
  localparam logic [1:0] CHAN_IN0 = 2'h0;
  localparam logic [1:0] CHAN_IN1 = 2'h1;
  localparam logic [1:0] CHAN_IN2 = 2'h2;
  localparam logic [1:0] CHAN_IN3 = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic BUSY_N_RESET = 1'h1;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
  localparam logic [4:0] HOST_PINS_IDLE = 5'h1C;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic chipSelN;
    logic convertN;
    logic readN;
    logic channel_sel_bit1;
    logic channel_sel_bit0;
  } adcpp_host_t;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [DATA_W-1:0] code;
  } adcpp_result_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACQ = 4'h2,
    ST_CONV = 4'h4,
    ST_DONE = 4'h8
  } adcpp_state_t;

endpackage

// >>> adcpp_port.sv
// Overview of operation
// - Chip select low with convert strobe low starts a new conversion.
// - Starting a conversion releases the parallel data outputs.
// - A qualified convert strobe chooses the sampled input from the address.
// - Busy goes low at conversion start and stays low throughout.
// - At completion busy rises and the data outputs take the new result.
// - Read strobe low with chip select low presents the result.
// - Address inputs are latched on rising edge of read or convert.
// - Latched address 00,01,10,11 selects input 0,1,2,3.
// - Each sample takes sixteen cycles of the external conversion clock.
// - Result sits on the data lines with line 0 the least significant.
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------------
module adcpp_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic isFull;
  logic isEmpty;
  logic doPush;
  logic doPop;

  assign isEmpty = (wrPtr_reg == rdPtr_reg);
  assign isFull = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) &&
                  (wrPtr_reg[AW] != rdPtr_reg[AW]);
  assign inReady = !isFull;
  assign outValid = !isEmpty;
  assign outData = mem[rdPtr_reg[AW-1:0]];
  assign doPush = inValid && !isFull;
  assign doPop = outReady && !isEmpty;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
    end else if (doPush) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdPtr_reg <= '0;
    end else if (doPop) begin
      rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule

// ------------------------------------------------------------------
// Conversion control and parallel read port
// ------------------------------------------------------------------
module adcpp_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host bus pins, asynchronous to clk
  input wire adcpp_pkg::adcpp_host_t hostPins,
  // External conversion clock pin, asynchronous to clk
  input wire logic convClk,
  // Digitised samples of the four inputs, on clk
  input wire logic [adcpp_pkg::DATA_W-1:0] analog_input_0,
  input wire logic [adcpp_pkg::DATA_W-1:0] analog_input_1,
  input wire logic [adcpp_pkg::DATA_W-1:0] analog_input_2,
  input wire logic [adcpp_pkg::DATA_W-1:0] analog_input_3,
  // Host bus outputs
  output logic busyN,
  output logic [adcpp_pkg::DATA_W-1:0] resultOut,
  output logic resultOe
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  localparam logic [NSYNC-1:0] SYNC_IDLE = {1'b0,
                                            adcpp_pkg::HOST_PINS_IDLE};

  logic [NSYNC-1:0] rawPins;
  logic [NSYNC-1:0] syncPins;
  logic [NSYNC-1:0] syncFirst_reg;
  logic [NSYNC-1:0] syncSecond_reg;

  assign rawPins = {convClk, hostPins};

  // Only the second stage is read; the first may still be settling.
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        syncFirst_reg[i] <= SYNC_IDLE[i];
        syncSecond_reg[i] <= SYNC_IDLE[i];
      end else begin
        syncFirst_reg[i] <= rawPins[i];
        syncSecond_reg[i] <= syncFirst_reg[i];
      end
    end
  end

  assign syncPins = syncSecond_reg;

  // ----------------------------------------------------------------
  // Strobe and clock edges
  // ----------------------------------------------------------------
  adcpp_pkg::adcpp_host_t syncHost;
  adcpp_pkg::adcpp_host_t prevHost_reg;
  logic syncConvClk;
  logic prevConvClk_reg;
  logic convTick;
  logic startReq;
  logic convRise;
  logic readRise;
  logic readActive;

  assign syncHost = syncPins[4:0];
  assign syncConvClk = syncPins[5];

  // Previous levels reset to the idle pin levels, so that no false
  // strobe edge follows reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prevHost_reg <= adcpp_pkg::HOST_PINS_IDLE;
      prevConvClk_reg <= 1'b0;
    end else begin
      prevHost_reg <= syncHost;
      prevConvClk_reg <= syncConvClk;
    end
  end

  // The conversion clock becomes a one-cycle enable on its rising edge.
  assign convTick = syncConvClk && !prevConvClk_reg;
  assign startReq = !syncHost.chipSelN && !syncHost.convertN &&
                    (prevHost_reg.chipSelN || prevHost_reg.convertN);
  assign convRise = syncHost.convertN && !prevHost_reg.convertN;
  assign readRise = syncHost.readN && !prevHost_reg.readN;
  assign readActive = !syncHost.chipSelN && !syncHost.readN;

  // ----------------------------------------------------------------
  // Channel address latch and input select
  // ----------------------------------------------------------------
  logic [adcpp_pkg::CHAN_W-1:0] chanLatch_reg;
  logic [adcpp_pkg::DATA_W-1:0] selCode;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chanLatch_reg <= adcpp_pkg::CHAN_IN0;
    end else if (convRise || readRise) begin
      chanLatch_reg <= {syncHost.channel_sel_bit1,
                        syncHost.channel_sel_bit0};
    end
  end

  always_comb begin
    case (chanLatch_reg)
      adcpp_pkg::CHAN_IN0: selCode = analog_input_0;
      adcpp_pkg::CHAN_IN1: selCode = analog_input_1;
      adcpp_pkg::CHAN_IN2: selCode = analog_input_2;
      adcpp_pkg::CHAN_IN3: selCode = analog_input_3;
      default: selCode = analog_input_0;
    endcase
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  adcpp_pkg::adcpp_state_t state_reg;
  adcpp_pkg::adcpp_state_t state_next;
  logic [3:0] convCnt_reg;
  logic lastTick;
  logic drainReady;
  logic popNow;
  logic fifoInReady;
  logic fifoOutValid;
  adcpp_pkg::adcpp_result_t fifoIn;
  adcpp_pkg::adcpp_result_t fifoOut;

  assign lastTick = (state_reg == adcpp_pkg::ST_CONV) && convTick &&
                    (convCnt_reg == adcpp_pkg::CONV_CNT_LAST);
  assign drainReady = (state_reg == adcpp_pkg::ST_DONE);
  assign popNow = drainReady && fifoOutValid;
  assign fifoIn.chan = chanLatch_reg;
  assign fifoIn.code = selCode;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adcpp_pkg::ST_IDLE: begin
        if (startReq) begin
          state_next = adcpp_pkg::ST_ACQ;
        end
      end
      adcpp_pkg::ST_ACQ: begin
        // The channel is only known once the convert strobe ends.
        if (convRise) begin
          state_next = adcpp_pkg::ST_CONV;
        end
      end
      adcpp_pkg::ST_CONV: begin
        // A full buffer holds the last count until the next tick.
        if (lastTick && fifoInReady) begin
          state_next = adcpp_pkg::ST_DONE;
        end
      end
      adcpp_pkg::ST_DONE: begin
        if (popNow) begin
          state_next = adcpp_pkg::ST_IDLE;
        end
      end
      default: state_next = adcpp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= adcpp_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      convCnt_reg <= adcpp_pkg::CONV_CNT_RESET;
    end else if (state_reg != adcpp_pkg::ST_CONV) begin
      convCnt_reg <= adcpp_pkg::CONV_CNT_RESET;
    end else if (convTick && convCnt_reg != adcpp_pkg::CONV_CNT_LAST) begin
      convCnt_reg <= convCnt_reg + 4'h1;
    end
  end

  adcpp_fifo #(
    .WIDTH(adcpp_pkg::CHAN_W + adcpp_pkg::DATA_W),
    .DEPTH(adcpp_pkg::FIFO_DEPTH)
  ) u_adcpp_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(lastTick),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .outData(fifoOut)
  );

  // ----------------------------------------------------------------
  // Host bus outputs
  // ----------------------------------------------------------------
  logic busyN_reg;
  logic resultOe_reg;
  logic [adcpp_pkg::DATA_W-1:0] resultOut_reg;

  // Busy mirrors the next state so that it falls on the start edge.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busyN_reg <= adcpp_pkg::BUSY_N_RESET;
    end else begin
      busyN_reg <= (state_next == adcpp_pkg::ST_IDLE);
    end
  end

  // Drive is dropped on the start edge and allowed again only with
  // busy high, so the bus never shows a half-finished result.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resultOe_reg <= 1'b0;
    end else begin
      resultOe_reg <= (state_next == adcpp_pkg::ST_IDLE) &&
                      readActive;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resultOut_reg <= adcpp_pkg::DATA_RESET;
    end else if (popNow) begin
      resultOut_reg <= fifoOut.code;
    end
  end

  assign busyN = busyN_reg;
  assign resultOe = resultOe_reg;
  assign resultOut = resultOut_reg;
endmodule

// >>> adcpp_port_chk.sv
`timescale 1ns/100ps
module adcpp_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Watched ports
  input wire adcpp_pkg::adcpp_host_t hostPins,
  input wire logic busyN,
  input wire logic [adcpp_pkg::DATA_W-1:0] resultOut,
  input wire logic resultOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  oe_busy_a: assert property (resultOe |-> busyN)
    else $error("data driven while busy");
  reset_idle_a: assert property ($rose(reset_n) |-> busyN)
    else $error("busy low out of reset");
  busy_hold_a: assert property ($fell(busyN) |-> !busyN [*8])
    else $error("conversion too short");
  busy_end_a: assert property ($fell(busyN) |-> ##[1:400] busyN)
    else $error("conversion never ends");
  fall_float_a: assert property ($fell(busyN) |-> !resultOe)
    else $error("outputs driven at start");
  conv_start_a: assert property (!hostPins.chipSelN &&
    $fell(hostPins.convertN) && busyN |-> ##[1:60] !busyN)
    else $error("start ignored");
  read_oe_a: assert property ((!hostPins.chipSelN &&
    !hostPins.readN && busyN) [*5] |-> resultOe)
    else $error("read not driven");
  data_hold_a: assert property (resultOe && $past(resultOe)
    |-> $stable(resultOut)) else $error("data moved");
  cover property ($fell(busyN));
  cover property ($rose(busyN));
  cover property ($rose(resultOe));
endmodule

// >>> adcpp_host.sv
`timescale 1ns/100ps
module adcpp_host (
  // Clock and status
  input wire logic clk,
  input wire logic busyN,
  // Host pins
  output adcpp_pkg::adcpp_host_t pins
);
  initial pins = adcpp_pkg::HOST_PINS_IDLE;
  task drive(input adcpp_pkg::adcpp_host_t p, input int n);
    @(posedge clk) pins <= p;
    repeat (n) @(posedge clk);
  endtask
  // Bounded so that a stuck busy flag shows as a failure, not a hang.
  task waitReady;
    repeat (400) if (busyN !== 1'b1) @(posedge clk);
  endtask
endmodule

// >>> adcpp_port_bench.sv
`timescale 1ns/100ps
`define CHK(n,e,s) begin checkCount++; if ((s) !== (e)) begin \
  nMismatch++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module adcpp_port_bench;
  logic clk = 0, reset_n = 0, convClk = 0, busyN, resultOe;
  logic [11:0] resultOut;
  logic [11:0] ain [4] = '{12'h801, 12'h402, 12'h204, 12'h108};
  adcpp_pkg::adcpp_host_t pins;
  int nMismatch = 0, checkCount = 0;
  always #10 clk = ~clk;
  always #50 convClk = ~convClk;
  adcpp_host u_host (.clk(clk), .busyN(busyN), .pins(pins));
  adcpp_port u_port (.clk(clk), .reset_n(reset_n), .hostPins(pins),
    .convClk(convClk), .analog_input_0(ain[0]), .analog_input_1(ain[1]),
    .analog_input_2(ain[2]), .analog_input_3(ain[3]), .busyN(busyN),
    .resultOut(resultOut), .resultOe(resultOe));
  task end_of_test;
    if (nMismatch == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task noSelect;
    u_host.drive(5'h14, 20);
    `CHK("busy", 1'b1, busyN)
    u_host.drive(adcpp_pkg::HOST_PINS_IDLE, 2);
  endtask
  task chanScan;
    for (int c = 0; c < 4; c++) begin
      u_host.drive({3'b001, 2'(c)}, 4);
      u_host.drive({3'b011, 2'(c)}, 4);
      `CHK("busy", 1'b0, busyN)
      `CHK("float", 1'b0, resultOe)
      u_host.waitReady();
      u_host.drive({3'b010, 2'(c)}, 6);
      `CHK("result", ain[c], resultOut)
      `CHK("drive", 1'b1, resultOe)
      u_host.drive({3'b011, 2'(c)}, 2);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1;
    noSelect();
    chanScan();
    end_of_test();
  end
  initial begin
    #60000;
    nMismatch++;
    end_of_test();
  end
endmodule
bind adcpp_port adcpp_port_chk u_chk (.clk(clk), .reset_n(reset_n),
  .hostPins(hostPins), .busyN(busyN), .resultOut(resultOut),
  .resultOe(resultOe));
